// ---- src/watchdog_with_timer_freeze.sv ----
// watchdog down-counter with guarded reload and timer freeze control
// assumes an apb master on pclk, a debug-halt pin from another domain
// and a software reset pulse from logic on pclk
//
// Operation
// - counter write needs upper seven bits zero
// - accepted write loads low eight bits
// - read live value, decrement each tick
// - nine-bit two's complement counter, sign bit
// - interrupt mode: nmi at zero, keep counting
// - interrupt mode: reset at 0x1F0, reload 0xFF
// - reset mode: reset at zero or below
// - reset mode ignores software watchdog freeze
// - mode bit set-only, cleared by resets
// - debug halt always freezes the counter
// - set bit 3 freezes watchdog if allowed
// - set bit 2 freezes link master clock
// - set bit 1 freezes software timer
// - set bit 0 freezes wake-up timer
// - clear register resumes matching frozen timer
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

module watchdog_with_timer_freeze #(
   parameter int unsigned TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // system
   input  wire logic        debug_halted_pin,
   input  wire logic        software_reset,
   output logic             nmi,
   output logic             watchdog_reset,
   output logic             irq,
   // freeze controls to the other timers
   output logic             freeze_link_master_clock,
   output logic             freeze_software_timer,
   output logic             freeze_wakeup_timer
);

   localparam int unsigned PRE_W = $clog2(TICK_CYCLES + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
   localparam logic [PRE_W-1:0] PRE_ZERO = '0;

   // word decode of the byte address against a register index
   function automatic logic addr_hit(
      input logic [31:0] a,
      input logic [31:0] idx
   );
      addr_hit = (a[31:2] == idx[29:0]);
   endfunction

   logic [wdt_pkg::CNT_W-1:0]  counter_value;
   logic [wdt_pkg::CNT_W-1:0]  next_counter;
   logic                       reset_mode;
   logic [wdt_pkg::FRZ_W-1:0]  freeze;
   logic [wdt_pkg::EV_W-1:0]   event_status;
   logic [wdt_pkg::EV_W-1:0]   event_enable;
   logic                       nmi_seen;
   logic                       rst_seen;
   logic [PRE_W-1:0]           prescale;
   logic [wdt_pkg::SYNC_STAGES-1:0] debug_sync;
   logic                       debug_halted;
   logic                       setup;
   logic                       wr;
   logic                       reload_write_guard;
   logic                       frozen;
   logic                       tick;
   logic                       nmi_event;
   logic                       reset_event;
   logic                       mapped;
   logic [31:0]                read_mux;
   logic                       wr_counter;
   logic                       wr_control;
   logic                       wr_freeze_set;
   logic                       wr_freeze_clear;
   logic                       wr_event_clear;
   logic                       wr_event_enable;
   logic                       counter_load;
   logic                       counter_step;
   logic                       prescale_wrap;
   logic                       counter_at_zero;
   logic                       counter_negative;
   logic                       mode_set_request;

   // bus phases
   assign setup = psel && !penable;
   assign wr    = psel && penable && pwrite;
   assign pready = 1'b1;

   // register write strobes, one per writable register
   assign wr_counter      = wr && addr_hit(paddr, wdt_pkg::IDX_COUNTER);
   assign wr_control      = wr && addr_hit(paddr, wdt_pkg::IDX_CONTROL);
   assign wr_freeze_set   = wr && addr_hit(paddr, wdt_pkg::IDX_FREEZE_SET);
   assign wr_freeze_clear = wr && addr_hit(paddr, wdt_pkg::IDX_FREEZE_CLEAR);
   assign wr_event_clear  = wr && addr_hit(paddr, wdt_pkg::IDX_EVENT_CLEAR);
   assign wr_event_enable = wr && addr_hit(paddr, wdt_pkg::IDX_EVENT_ENABLE);

   // software asks for reset mode
   assign mode_set_request =
      wr_control && pwdata[wdt_pkg::CTRL_MODE_BIT];

   // guard field must be all zero to reload
   assign reload_write_guard =
      (pwdata[wdt_pkg::GUARD_HI:wdt_pkg::GUARD_LO] ==
       wdt_pkg::GUARD_OPEN);

   // debug halt pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         debug_sync <= '0;
      end else begin
         debug_sync <= {debug_sync[wdt_pkg::SYNC_STAGES-2:0],
                        debug_halted_pin};
      end
   end

   // debug halt level once the last two stages agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         debug_halted <= 1'b0;
      end else if (debug_sync[1] == debug_sync[2]) begin
         debug_halted <= debug_sync[2];
      end
   end

   // effective watchdog freeze
   assign frozen = debug_halted ||
      (freeze[wdt_pkg::FRZ_WATCHDOG_BIT] && !reset_mode);

   // time base prescaler, held while frozen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= PRE_ZERO;
      end else if (software_reset) begin
         prescale <= PRE_ZERO;
      end else if (!frozen) begin
         if (prescale_wrap) begin
            prescale <= PRE_ZERO;
         end else begin
            prescale <= prescale + PRE_W'(1);
         end
      end
   end

   assign prescale_wrap = (prescale == PRE_LAST);
   assign tick          = !frozen && prescale_wrap;

   // nine-bit wrap past zero into negatives
   assign next_counter = counter_value - wdt_pkg::CNT_STEP;

   assign counter_at_zero  = (counter_value == wdt_pkg::CNT_NMI_AT);
   assign counter_negative = counter_value[wdt_pkg::SIGN_BIT];

   // nmi only when the tick really lands on zero
   assign nmi_event = counter_step && !reset_mode &&
                      (next_counter == wdt_pkg::CNT_NMI_AT);

   // reset event beats a reload, a reload beats a tick
   assign counter_load = wr_counter && reload_write_guard;
   assign counter_step = tick && !counter_load && !reset_event;

   always_comb begin
      if (reset_mode) begin
         reset_event = counter_at_zero || counter_negative;
      end else begin
         reset_event =
            (counter_value == wdt_pkg::CNT_RESET_AT);
      end
   end

   // counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value <= wdt_pkg::CNT_RESET;
      end else if (software_reset) begin
         counter_value <= wdt_pkg::CNT_RESET;
      end else if (reset_event) begin
         counter_value <= wdt_pkg::CNT_RELOAD;
      end else if (counter_load) begin
         counter_value <= {1'b0,
                           pwdata[wdt_pkg::VAL_HI:0]};
      end else if (counter_step) begin
         counter_value <= next_counter;
      end
   end

   // response mode, set-only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_mode <= 1'b0;
      end else if (software_reset || reset_event) begin
         reset_mode <= 1'b0;
      end else if (mode_set_request) begin
         reset_mode <= 1'b1;
      end
   end

   // freeze state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freeze <= wdt_pkg::FRZ_RESET;
      end else if (software_reset) begin
         freeze <= wdt_pkg::FRZ_RESET;
      end else if (wr_freeze_set) begin
         freeze[wdt_pkg::FRZ_LINK_BIT] <= freeze[wdt_pkg::FRZ_LINK_BIT] |
            pwdata[wdt_pkg::FRZ_LINK_BIT];
         freeze[wdt_pkg::FRZ_SWTIMER_BIT] <=
            freeze[wdt_pkg::FRZ_SWTIMER_BIT] |
            pwdata[wdt_pkg::FRZ_SWTIMER_BIT];
         freeze[wdt_pkg::FRZ_WAKEUP_BIT] <=
            freeze[wdt_pkg::FRZ_WAKEUP_BIT] |
            pwdata[wdt_pkg::FRZ_WAKEUP_BIT];
         freeze[wdt_pkg::FRZ_WATCHDOG_BIT] <=
            freeze[wdt_pkg::FRZ_WATCHDOG_BIT] |
            (pwdata[wdt_pkg::FRZ_WATCHDOG_BIT] &&
             !reset_mode);
      end else if (wr_freeze_clear) begin
         freeze <= freeze &
            ~pwdata[wdt_pkg::FRZ_W-1:0];
      end
   end

   assign freeze_link_master_clock =
      freeze[wdt_pkg::FRZ_LINK_BIT];
   assign freeze_software_timer   = freeze[wdt_pkg::FRZ_SWTIMER_BIT];
   assign freeze_wakeup_timer     = freeze[wdt_pkg::FRZ_WAKEUP_BIT];

   // interrupt pulse to the system
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi <= 1'b0;
      end else begin
         nmi <= nmi_event;
      end
   end

   // system reset pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_reset <= 1'b0;
      end else begin
         watchdog_reset <= reset_event;
      end
   end

   // sticky interrupt flag, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_seen <= 1'b0;
      end else if (nmi_event) begin
         nmi_seen <= 1'b1;
      end else if (wr_event_clear &&
                   pwdata[wdt_pkg::EV_NMI_BIT]) begin
         nmi_seen <= 1'b0;
      end
   end

   // sticky reset flag, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_seen <= 1'b0;
      end else if (reset_event) begin
         rst_seen <= 1'b1;
      end else if (wr_event_clear &&
                   pwdata[wdt_pkg::EV_RST_BIT]) begin
         rst_seen <= 1'b0;
      end
   end

   // status word for reads and the interrupt
   always_comb begin
      event_status = wdt_pkg::EV_RESET;
      event_status[wdt_pkg::EV_NMI_BIT] = nmi_seen;
      event_status[wdt_pkg::EV_RST_BIT] = rst_seen;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_enable <= wdt_pkg::EV_RESET;
      end else if (wr_event_enable) begin
         event_enable <= pwdata[wdt_pkg::EV_W-1:0];
      end
   end

   assign irq = |(event_status & event_enable);

   // read decode
   always_comb begin
      read_mux = '0;
      mapped   = 1'b1;
      if (addr_hit(paddr, wdt_pkg::IDX_COUNTER)) begin
         read_mux[wdt_pkg::CNT_W-1:0] = counter_value;
      end else if (addr_hit(paddr, wdt_pkg::IDX_CONTROL)) begin
         read_mux[wdt_pkg::CTRL_MODE_BIT] = reset_mode;
      end else if (addr_hit(paddr, wdt_pkg::IDX_FREEZE_SET) ||
                   addr_hit(paddr, wdt_pkg::IDX_FREEZE_CLEAR)) begin
         read_mux[wdt_pkg::FRZ_W-1:0] = freeze;
      end else if (addr_hit(paddr, wdt_pkg::IDX_EVENT_STATUS)) begin
         read_mux[wdt_pkg::EV_W-1:0] = event_status;
      end else if (addr_hit(paddr, wdt_pkg::IDX_EVENT_CLEAR)) begin
         read_mux = '0;
      end else if (addr_hit(paddr, wdt_pkg::IDX_EVENT_ENABLE)) begin
         read_mux[wdt_pkg::EV_W-1:0] = event_enable;
      end else begin
         mapped = 1'b0;
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : read_mux;
      end
   end

   // error captured in the setup cycle, dropped when idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= !mapped;
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

endmodule

// ---- src/wdt_pkg.sv ----
// constants shared by the watchdog and timer-freeze block
// assumes a 25 MHz register clock and a 32-bit apb register bus
package wdt_pkg;

   // time base
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned TICK_TIME_US  = 10240;
   localparam int unsigned TICK_CYCLES   =
      (TICK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // synchroniser depth for pin inputs
   localparam int unsigned SYNC_STAGES = 3;

   // register indices, byte address is four times the index
   localparam logic [31:0] IDX_COUNTER      = 32'h5000_3100;
   localparam logic [31:0] IDX_CONTROL      = 32'h5000_3102;
   localparam logic [31:0] IDX_FREEZE_SET   = 32'h5000_3300;
   localparam logic [31:0] IDX_FREEZE_CLEAR = 32'h5000_3302;
   localparam logic [31:0] IDX_EVENT_STATUS = 32'h5000_3400;
   localparam logic [31:0] IDX_EVENT_CLEAR  = 32'h5000_3401;
   localparam logic [31:0] IDX_EVENT_ENABLE = 32'h5000_3402;

   // counter layout and values
   localparam int unsigned CNT_W         = 9;
   localparam int unsigned GUARD_HI      = 15;
   localparam int unsigned GUARD_LO      = 9;
   localparam int unsigned VAL_HI        = 7;
   localparam int unsigned SIGN_BIT      = 8;
   localparam logic [8:0]  CNT_RESET     = 9'h0FF;
   localparam logic [8:0]  CNT_RELOAD    = 9'h0FF;
   localparam logic [8:0]  CNT_NMI_AT    = 9'h000;
   localparam logic [8:0]  CNT_RESET_AT  = 9'h1F0;
   localparam logic [8:0]  CNT_STEP      = 9'h001;
   localparam logic [6:0]  GUARD_OPEN    = 7'h00;

   // control layout
   localparam int unsigned CTRL_MODE_BIT = 0;

   // freeze layout
   localparam int unsigned FRZ_W             = 4;
   localparam int unsigned FRZ_WATCHDOG_BIT  = 3;
   localparam int unsigned FRZ_LINK_BIT      = 2;
   localparam int unsigned FRZ_SWTIMER_BIT   = 1;
   localparam int unsigned FRZ_WAKEUP_BIT    = 0;
   localparam logic [3:0]  FRZ_RESET         = 4'h0;

   // event layout
   localparam int unsigned EV_W        = 2;
   localparam int unsigned EV_NMI_BIT  = 0;
   localparam int unsigned EV_RST_BIT  = 1;
   localparam logic [1:0]  EV_RESET    = 2'h0;

endpackage

// ---- test/wdt_checker_asserts.sv ----
// assertions on the ports of the watchdog and timer-freeze block
// bound into every instance of the block, one clock domain
`timescale 1ns/1ps
module wdt_checker (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   // system
   input wire logic        debug_halted_pin,
   input wire logic        software_reset,
   input wire logic        nmi,
   input wire logic        watchdog_reset,
   input wire logic        freeze_link_master_clock,
   input wire logic        freeze_software_timer,
   input wire logic        freeze_wakeup_timer
);
   logic [2:0] frz;
   logic       acc;
   logic       wr_set;
   logic       wr_clr;
   assign frz = {freeze_link_master_clock, freeze_software_timer,
      freeze_wakeup_timer};
   assign acc = psel && penable && pwrite;
   assign wr_set = acc && paddr == wdt_pkg::IDX_FREEZE_SET << 2;
   assign wr_clr = acc && paddr == wdt_pkg::IDX_FREEZE_CLEAR << 2;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_halt;
      debug_halted_pin [*6];
   endsequence
   property p_halt;
      s_halt |-> !nmi && !watchdog_reset;
   endproperty
   a_halt: assert property (p_halt)
      else $error("watchdog event while halted");
   property p_nmi_pulse;
      nmi |=> !nmi;
   endproperty
   a_nmi_pulse: assert property (p_nmi_pulse)
      else $error("nmi pulse too long");
   property p_rst_pulse;
      watchdog_reset |=> !watchdog_reset;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse)
      else $error("reset pulse too long");
   property p_excl;
      watchdog_reset |-> !nmi;
   endproperty
   a_excl: assert property (p_excl)
      else $error("nmi together with reset");
   property p_set;
      wr_set |=> (frz & $past(pwdata[2:0])) == $past(pwdata[2:0]);
   endproperty
   a_set: assert property (p_set)
      else $error("freeze set lost");
   property p_rise;
      !wr_set |=> (frz & ~$past(frz)) == 3'h0;
   endproperty
   a_rise: assert property (p_rise)
      else $error("freeze rose without set");
   property p_clear;
      wr_clr |=> (frz & $past(pwdata[2:0])) == 3'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("freeze clear lost");
   property p_keep;
      !wr_clr && !software_reset |=> (frz & $past(frz)) == $past(frz);
   endproperty
   a_keep: assert property (p_keep)
      else $error("freeze dropped");
endmodule

bind watchdog_with_timer_freeze wdt_checker chk_u (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .debug_halted_pin, .software_reset, .nmi, .watchdog_reset,
   .freeze_link_master_clock, .freeze_software_timer,
   .freeze_wakeup_timer);

// ---- test/wdt_system_model.sv ----
// system logic fed by the watchdog: counts its pulses
// and the cycles from an interrupt to the next watchdog reset
`timescale 1ns/1ps
module wdt_system_model (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // watchdog events
   input  wire logic        nmi,
   input  wire logic        watchdog_reset,
   // observations
   output logic      [15:0] nmi_count,
   output logic      [15:0] rst_count,
   output logic      [15:0] gap
);
   logic [15:0] since;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {nmi_count, rst_count, gap, since} <= '0;
      end else begin
         since <= nmi ? 16'h0001 : since + 16'h0001;
         if (nmi)
            nmi_count <= nmi_count + 16'h0001;
         if (watchdog_reset) begin
            rst_count <= rst_count + 16'h0001;
            gap <= since;
         end
      end
   end
endmodule

// ---- test/watchdog_with_timer_freeze_bench.sv ----
// self-checking bench for the watchdog with timer freeze
// reads are noted in a queue and checked by a monitor process
`timescale 1ns/1ps
module watchdog_with_timer_freeze_bench;
   localparam int unsigned T = 16;
   localparam logic [31:0] A_CNT = wdt_pkg::IDX_COUNTER << 2;
   localparam logic [31:0] A_CTL = wdt_pkg::IDX_CONTROL << 2;
   localparam logic [31:0] A_SET = wdt_pkg::IDX_FREEZE_SET << 2;
   localparam logic [31:0] A_CLR = wdt_pkg::IDX_FREEZE_CLEAR << 2;
   localparam logic [31:0] A_ST  = wdt_pkg::IDX_EVENT_STATUS << 2;
   localparam logic [31:0] A_EVC = wdt_pkg::IDX_EVENT_CLEAR << 2;
   localparam logic [31:0] A_EN  = wdt_pkg::IDX_EVENT_ENABLE << 2;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        debug_halted_pin, software_reset, nmi, watchdog_reset, irq;
   logic [31:0] paddr, pwdata, prdata;
   logic [31:0] r = 32'h0001737F;
   logic [2:0]  frz;
   logic [15:0] nmi_count, rst_count, gap;
   logic [36:0] notes[$];
   int          err_count = 0;
   int          checks = 0;
   watchdog_with_timer_freeze #(.TICK_CYCLES(T)) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .debug_halted_pin, .software_reset, .nmi,
      .watchdog_reset, .irq, .freeze_link_master_clock(frz[2]),
      .freeze_software_timer(frz[1]), .freeze_wakeup_timer(frz[0]));
   wdt_system_model sys_u (.pclk, .presetn, .nmi, .watchdog_reset,
      .nmi_count, .rst_count, .gap);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [36:0] got, input logic [36:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [31:0] a, d, input logic w);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] a, d);
      apb(a, d, 1'b1);
   endtask
   task automatic rd(input logic [31:0] a, d, input logic [4:0] p);
      notes.push_back({p, d});
      apb(a, 32'h0, 1'b0);
   endtask
   task automatic wait_ev(input logic sel);
      logic [15:0] c;
      c = sel ? rst_count : nmi_count;
      repeat (600) if ((sel ? rst_count : nmi_count) === c) @(posedge pclk);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge pclk)
      if (psel && penable && !pwrite && pready && notes.size() > 0)
         chk({pslverr, irq, frz, prdata}, notes.pop_front());
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      wrap_up();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {presetn, debug_halted_pin, software_reset} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wr(A_SET, 32'h8);
      rd(A_CNT, 32'hFF, 5'h00);
      rd(A_CTL, 32'h0, 5'h00);
      rd(A_SET, 32'h8, 5'h00);
      rd(A_CNT + 32'h4, 32'h0, 5'h10);
      repeat (4 * T) @(posedge pclk);
      rd(A_CNT, 32'hFF, 5'h00);
      repeat (4) begin
         r = lfsr(r);
         wr(A_CNT, r & 32'hFFFF01FF);
         wr(A_CNT, ~r | 32'h00000200);
         rd(A_CNT, {24'h0, r[7:0]}, 5'h00);
      end
      wr(A_SET, 32'h7);
      wr(A_SET, 32'h0);
      rd(A_SET, 32'hF, 5'h07);
      wr(A_CLR, 32'h6);
      rd(A_CLR, 32'h9, 5'h01);
      wr(A_EN, 32'h3);
      wr(A_CNT, 32'h2);
      wr(A_CLR, 32'h8);
      wait_ev(1'b0);
      repeat (20) @(posedge pclk);
      rd(A_CNT, 32'h1FF, 5'h09);
      rd(A_ST, 32'h1, 5'h09);
      wait_ev(1'b1);
      chk({36'h0, gap >= 16 * T - 1 && gap <= 16 * T + 2}, 37'h1);
      rd(A_ST, 32'h3, 5'h09);
      wr(A_EVC, 32'h3);
      wr(A_CTL, 32'h0);
      rd(A_CTL, 32'h0, 5'h01);
      wr(A_CTL, 32'h1);
      wr(A_SET, 32'h8);
      rd(A_SET, 32'h1, 5'h01);
      wr(A_CNT, 32'h3);
      wait_ev(1'b1);
      chk({21'h0, nmi_count}, 37'h1);
      chk({21'h0, rst_count}, 37'h2);
      rd(A_CTL, 32'h0, 5'h09);
      wr(A_EN, 32'h1);
      rd(A_ST, 32'h2, 5'h01);
      wr(A_EVC, 32'h2);
      rd(A_ST, 32'h0, 5'h01);
      debug_halted_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      wr(A_CNT, 32'h40);
      repeat (4 * T) @(posedge pclk);
      rd(A_CNT, 32'h40, 5'h01);
      software_reset <= 1'b1;
      @(posedge pclk);
      software_reset <= 1'b0;
      rd(A_CNT, 32'hFF, 5'h00);
      rd(A_SET, 32'h0, 5'h00);
      debug_halted_pin <= 1'b0;
      repeat (2) @(posedge pclk);
      wrap_up();
   end
endmodule
